// *** src/msr_top.sv ***
// Top of the monitor status register bank: status words, counters, fault flags and register port.
//
// How it works
// - Bit 1 of the upper status word shows 0 on the internal oscillator and 1 on an external clock.
// - Bit 0 of the upper status word shows 0 in active mode and 1 in standby or power-down.
// - Bits 15:14 count completed auxiliary A sequences, wrapping, cleared by disable, standby or reset.
// - Bits 13:12 count completed auxiliary B sequences, wrapping, cleared by disable, standby or reset.
// - Bits 11:10 count completed precision A conversions, wrapping, cleared by disable, standby or reset.
// - Bits 9:8 count completed precision B conversions, wrapping, cleared by disable, standby or reset.
// - Bits 7:2 of the lower status word always read zero.
// - Bit 1 of the lower status word reads 1 while an auxiliary A sequence runs and auxiliary A is enabled.
// - Bit 0 of the lower status word reads 1 while an auxiliary B sequence runs and auxiliary B is enabled.
// - The lower status word sits at 02h and reads 0000h after reset.
// - The supply fault register sits at 03h with sixteen flags that reset to FFFFh.
// - A fault flag reads 0 once its fault occurred and writing 1 restores it to 1 unless the fault is still present.
//
// Our own choice: strobed register access.
`timescale 1ns/1ns
module msr_top
    import msr_pkg::*;
(
    // Clock, reset and clock enable.
    input  wire logic              clk,
    input  wire logic              sys_rst,
    input  wire logic              ce,
    // Register port.
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [DATA_W-1:0] reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic [DATA_W-1:0]      reg_rdata_q,
    // Device state from the core logic on this clock.
    input  wire logic              ext_clock_sel,
    input  wire logic              standby_mode,
    input  wire logic [3:0]        conv_enable,
    input  wire logic [3:0]        conv_done,
    input  wire logic [1:0]        seq_running,
    // Supply monitor detector levels from the analog side, high while a fault is present.
    input  wire logic [DATA_W-1:0] supply_fault_raw,
    // Mirrors of the lower status word and the fault flags for the core.
    output logic [DATA_W-1:0]      lower_status_q,
    output logic [DATA_W-1:0]      supply_fault_q
);

    // Bundled request and converter activity.
    msr_req_s              req;
    msr_conv_s             conv;
    logic [DATA_W-1:0]     fault_meta_q;
    logic [DATA_W-1:0]     fault_sync_q;
    logic                  standby_q;
    logic                  standby_entry;
    logic [CNT_W-1:0]      cnt [NUM_CONV];
    logic [1:0]            running_q;
    logic [1:0]            upper_q;
    logic [DATA_W-1:0]     flags;
    logic [DATA_W-1:0]     lower_d;
    logic [DATA_W-1:0]     upper_d;
    logic [DATA_W-1:0]     rdata_d;
    logic                  fault_wr;

    // Group the ports into their carriers.
    assign req  = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
    assign conv = '{enable: conv_enable, done: conv_done, seq_running: seq_running};

    // Detector levels come from another domain, so they pass two flip-flops first.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            fault_meta_q <= 16'h0000;
            fault_sync_q <= 16'h0000;
        end else if (ce) begin
            fault_meta_q <= supply_fault_raw;
            fault_sync_q <= fault_meta_q;
        end
    end

    // Remember the mode to find the entry into standby or power-down.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            standby_q <= 1'b0;
        end else if (ce) begin
            standby_q <= standby_mode;
        end
    end

    // Counters are also held clear for as long as standby lasts, which covers the entry edge too.
    assign standby_entry = standby_mode & ~standby_q;

    // One counter per converter, cleared by disable or standby and advanced by its completion pulse.
    for (genvar i = 0; i < NUM_CONV; i++) begin : g_cnt
        msr_counter u_cnt (
            .clk     (clk),
            .sys_rst (sys_rst),
            .ce      (ce),
            .clr     (~conv.enable[i] | standby_mode | standby_entry),
            .inc     (conv.done[i]),
            .count_q (cnt[i])
        );
    end

    // Sequence running flags follow the sequencers; a disabled converter never shows one.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            running_q <= 2'b00;
        end else if (ce) begin
            running_q[1] <= conv.seq_running[1] & conv.enable[IDX_AUX_A];
            running_q[0] <= conv.seq_running[0] & conv.enable[IDX_AUX_B];
        end
    end

    // Clock source and mode indications.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            upper_q <= 2'b00;
        end else if (ce) begin
            upper_q[POS_CLOCK_SRC] <= ext_clock_sel;
            upper_q[POS_MODE]      <= standby_mode;
        end
    end

    // Restores are only written through the supply fault offset.
    assign fault_wr = req.wr & (req.addr == OFF_SUPPLY_FAULT);

    // Sticky flags: detector clears to 0, only a written 1 or a reset brings a flag back.
    msr_fault_flags u_flags (
        .clk        (clk),
        .sys_rst    (sys_rst),
        .ce         (ce),
        .fault_seen (fault_sync_q),
        .wr_en      (fault_wr),
        .wdata      (req.wdata),
        .flags_q    (flags)
    );

    // Assemble the lower and upper status words; reserved bits are tied to zero.
    always_comb begin
        lower_d = RST_LOWER_STATUS;
        lower_d[POS_AUX_A_CNT  +: CNT_W] = cnt[IDX_AUX_A];
        lower_d[POS_AUX_B_CNT  +: CNT_W] = cnt[IDX_AUX_B];
        lower_d[POS_PREC_A_CNT +: CNT_W] = cnt[IDX_PREC_A];
        lower_d[POS_PREC_B_CNT +: CNT_W] = cnt[IDX_PREC_B];
        lower_d[POS_AUX_A_RUN] = running_q[1];
        lower_d[POS_AUX_B_RUN] = running_q[0];
        upper_d = RST_UPPER_STATUS;
        upper_d[1:0] = upper_q;
    end

    // Read mux; unmapped offsets read as zero and writes there are ignored.
    always_comb begin
        case (req.addr)
            OFF_UPPER_STATUS: rdata_d = upper_d;
            OFF_LOWER_STATUS: rdata_d = lower_d;
            OFF_SUPPLY_FAULT: rdata_d = flags;
            default:          rdata_d = UNMAPPED_READ;
        endcase
    end

    // Read data stand in the cycle after the strobe only, zero otherwise.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            reg_rdata_q <= 16'h0000;
        end else if (ce) begin
            reg_rdata_q <= req.rd ? rdata_d : 16'h0000;
        end
    end

    // Registered mirrors so every output comes from a flip-flop.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            lower_status_q <= RST_LOWER_STATUS;
            supply_fault_q <= RST_SUPPLY_FAULT;
        end else if (ce) begin
            lower_status_q <= lower_d;
            supply_fault_q <= flags;
        end
    end

endmodule

// *** src/msr_pkg.sv ***
// Package for the monitor status register bank: offsets, field positions, reset values, carriers.
package msr_pkg;

    // Register word width and address width.
    localparam int unsigned DATA_W = 16;
    localparam int unsigned ADDR_W = 8;

    // Register offsets.
    localparam logic [7:0] OFF_UPPER_STATUS = 8'h01;
    localparam logic [7:0] OFF_LOWER_STATUS = 8'h02;
    localparam logic [7:0] OFF_SUPPLY_FAULT = 8'h03;

    // Reset values.
    localparam logic [15:0] RST_LOWER_STATUS = 16'h0000;
    localparam logic [15:0] RST_SUPPLY_FAULT = 16'hffff;
    localparam logic [15:0] RST_UPPER_STATUS = 16'h0000;
    localparam logic [15:0] UNMAPPED_READ    = 16'h0000;

    // Upper status word field positions.
    localparam int unsigned POS_CLOCK_SRC = 1;
    localparam int unsigned POS_MODE      = 0;

    // Lower status word field positions.
    localparam int unsigned POS_AUX_A_CNT  = 14;
    localparam int unsigned POS_AUX_B_CNT  = 12;
    localparam int unsigned POS_PREC_A_CNT = 10;
    localparam int unsigned POS_PREC_B_CNT = 8;
    localparam int unsigned POS_AUX_A_RUN  = 1;
    localparam int unsigned POS_AUX_B_RUN  = 0;

    // Counter width and clear value.
    localparam int unsigned CNT_W   = 2;
    localparam logic [1:0]  CNT_CLR = 2'h0;

    // Converter index order in the event and enable vectors.
    localparam int unsigned NUM_CONV = 4;
    localparam int unsigned IDX_AUX_A  = 3;
    localparam int unsigned IDX_AUX_B  = 2;
    localparam int unsigned IDX_PREC_A = 1;
    localparam int unsigned IDX_PREC_B = 0;

    // Register port request carrier.
    typedef struct packed {
        logic [7:0]  addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } msr_req_s;

    // Converter activity carrier: enable and done hold one bit per converter in index order, seq_running one bit per auxiliary sequencer.
    typedef struct packed {
        logic [3:0] enable;
        logic [3:0] done;
        logic [1:0] seq_running;
    } msr_conv_s;

endpackage

// *** src/msr_counter.sv ***
// Two-bit wrapping completion counter with a clear input.
`timescale 1ns/1ns
module msr_counter
    import msr_pkg::*;
(
    // Clock and control.
    input  wire logic             clk,
    input  wire logic             sys_rst,
    input  wire logic             ce,
    // Events.
    input  wire logic             clr,
    input  wire logic             inc,
    // Count.
    output logic [CNT_W-1:0]      count_q
);

    // Clear wins over an increment in the same cycle, so a disable never leaves a stale count.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            count_q <= CNT_CLR;
        end else if (ce) begin
            if (clr) begin
                count_q <= CNT_CLR;
            end else if (inc) begin
                count_q <= count_q + 2'h1;
            end
        end
    end

endmodule

// *** src/msr_fault_flags.sv ***
// Sticky active-low supply fault flags with write-one-to-restore.
`timescale 1ns/1ns
module msr_fault_flags
    import msr_pkg::*;
(
    // Clock and control.
    input  wire logic              clk,
    input  wire logic              sys_rst,
    input  wire logic              ce,
    // Detector levels, already synchronised, high while a fault is present.
    input  wire logic [DATA_W-1:0] fault_seen,
    // Software restore.
    input  wire logic              wr_en,
    input  wire logic [DATA_W-1:0] wdata,
    // Flags.
    output logic [DATA_W-1:0]      flags_q
);

    // A detected fault beats a restore in the same cycle, so no fault is lost.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            flags_q <= RST_SUPPLY_FAULT;
        end else if (ce) begin
            flags_q <= (flags_q | (wr_en ? wdata : 16'h0000)) & ~fault_seen;
        end
    end

endmodule

// *** sim/msr_props.sv ***
// Port assertions for the monitor status register bank.
`timescale 1ns/1ns
module msr_props
    import msr_pkg::*;
(
    // Clock, reset and register port.
    input wire logic        clk, sys_rst, ce, reg_wr, reg_rd,
    input wire logic [7:0]  reg_addr,
    input wire logic [15:0] reg_wdata, reg_rdata_q,
    // Device state, detectors and mirrors.
    input wire logic        ext_clock_sel, standby_mode,
    input wire logic [3:0]  conv_enable, conv_done,
    input wire logic [1:0]  seq_running,
    input wire logic [15:0] supply_fault_raw, lower_status_q, supply_fault_q
);
    // Frozen state under a low enable breaks every timing relation, so it is excluded.
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst || !ce);
    wire w_fault = reg_wr && reg_addr == OFF_SUPPLY_FAULT;

    a_reserved_zero: assert property (lower_status_q[7:2] == 6'h00)
        else $error("reserved status bits set");
    a_read_lower: assert property (reg_rd && reg_addr == OFF_LOWER_STATUS |=> reg_rdata_q == lower_status_q)
        else $error("lower word read mismatch");
    a_read_fault: assert property (reg_rd && reg_addr == OFF_SUPPLY_FAULT |=> reg_rdata_q == supply_fault_q)
        else $error("fault word read mismatch");
    a_rdata_idle: assert property (!reg_rd |=> reg_rdata_q == 16'h0000)
        else $error("read data outside read slot");
    a_upper_read: assert property (reg_rd && reg_addr == OFF_UPPER_STATUS && $stable(ext_clock_sel)
        && $stable(standby_mode) |=> reg_rdata_q == {14'h0000, $past(ext_clock_sel), $past(standby_mode)})
        else $error("upper word read mismatch");
    a_standby_clear: assert property (standby_mode |-> ##2 lower_status_q[15:8] == 8'h00)
        else $error("counters not cleared in standby");
    a_disable_clear: assert property (!conv_enable[IDX_AUX_A] |-> ##2 lower_status_q[15:14] == 2'h0)
        else $error("aux a counter not cleared");
    a_count_step: assert property (conv_done[IDX_PREC_A] && conv_enable[IDX_PREC_A] && !standby_mode
        |=> ##1 lower_status_q[11:10] == 2'($past(lower_status_q[11:10]) + 2'h1))
        else $error("precision a counter step wrong");
    a_run_flags: assert property (seq_running == 2'h3 && conv_enable[3:2] == 2'h3
        |-> ##2 lower_status_q[1:0] == 2'h3)
        else $error("running flags not shown");
    a_fault_sticky: assert property (!$past(w_fault, 2) |-> (supply_fault_q & ~$past(supply_fault_q)) == 16'h0000)
        else $error("fault flag rose without write");
    a_fault_set: assert property (supply_fault_raw[15] [*4] |-> ##2 !supply_fault_q[15])
        else $error("fault flag not set");
    c_wrap: cover property (lower_status_q[9:8] == 2'h3 ##1 lower_status_q[9:8] == 2'h0);
    c_fault: cover property (supply_fault_q != 16'hffff);
    c_standby: cover property (standby_mode && reg_rd);
endmodule

bind msr_top msr_props u_props (
    .clk              (clk),
    .sys_rst          (sys_rst),
    .ce               (ce),
    .reg_wr           (reg_wr),
    .reg_rd           (reg_rd),
    .reg_addr         (reg_addr),
    .reg_wdata        (reg_wdata),
    .reg_rdata_q      (reg_rdata_q),
    .ext_clock_sel    (ext_clock_sel),
    .standby_mode     (standby_mode),
    .conv_enable      (conv_enable),
    .conv_done        (conv_done),
    .seq_running      (seq_running),
    .supply_fault_raw (supply_fault_raw),
    .lower_status_q   (lower_status_q),
    .supply_fault_q   (supply_fault_q)
);

// *** sim/msr_host.sv ***
// Host model that reaches the status registers over the register port.
`timescale 1ns/1ns
module msr_host (
    // Clock.
    input  wire logic        clk,
    // Register port toward the device.
    output logic [7:0]       reg_addr = 8'h00,
    output logic [15:0]      reg_wdata = 16'h0000,
    output logic             reg_wr = 1'b0,
    output logic             reg_rd = 1'b0,
    input  wire logic [15:0] reg_rdata_q
);
    // Only status places are written, never converter setup while it runs.
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    // Read data stand for one cycle only, so they are taken at the next rising edge, before they drop to zero.
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(posedge clk);
        d = reg_rdata_q;
    endtask
endmodule

// *** sim/testbench.sv ***
// Self-checking testbench for the monitor status register bank.
`timescale 1ns/1ns
module testbench;
    import msr_pkg::*;
    logic        clk = 1'b0, sys_rst = 1'b1, ext_clock_sel = 1'b0, standby_mode = 1'b0, ce = 1'b1;
    logic [3:0]  conv_enable = 4'hf, conv_done = 4'h0;
    logic [1:0]  seq_running = 2'h0;
    logic [15:0] supply_fault_raw = 16'h0000, reg_wdata, reg_rdata_q;
    logic [7:0]  reg_addr;
    logic        reg_wr, reg_rd;
    logic [1:0]  cnt [4];
    int          n_mismatch = 0, check_count = 0;

    always #50 clk = ~clk;
    msr_host u_host (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q));
    msr_top u_dut (.clk(clk), .sys_rst(sys_rst), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .ext_clock_sel(ext_clock_sel),
        .standby_mode(standby_mode), .conv_enable(conv_enable), .conv_done(conv_done),
        .seq_running(seq_running), .supply_fault_raw(supply_fault_raw), .lower_status_q(),
        .supply_fault_q());

    // Expected lower word from the bench's own counts.
    function automatic logic [15:0] exp_lower(input logic [1:0] run);
        return {cnt[3], cnt[2], cnt[1], cnt[0], 6'h00, run};
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rc(input logic [7:0] a, input logic [15:0] exp);
        logic [15:0] v;
        u_host.rd(a, v);
        chk(v, exp);
    endtask
    // Random completions; a pulse counts only while enabled, active and clocked.
    task automatic rnd(input int n);
        logic [31:0] d;
        repeat (n) begin
            @(posedge clk);
            d = $urandom;
            conv_done <= d[3:0];
            for (int i = 0; i < 4; i++)
                if (d[i] && conv_enable[i] && !standby_mode && ce) cnt[i] = cnt[i] + 2'h1;
        end
        @(posedge clk);
        conv_done <= 4'h0;
        repeat (3) @(posedge clk);
    endtask
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // A hang is cut short and counted.
    initial begin
        #2000000;
        n_mismatch++;
        close_out;
    end
    initial begin
        void'($urandom(57593));
        foreach (cnt[i]) cnt[i] = 2'h0;
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        rc(OFF_LOWER_STATUS, 16'h0000);
        rc(OFF_SUPPLY_FAULT, 16'hffff);
        rc(8'h55, 16'h0000);
        for (int k = 0; k < 4; k++) begin
            {ext_clock_sel, standby_mode} <= 2'(k);
            repeat (2) @(posedge clk);
            rc(OFF_UPPER_STATUS, 16'(k));
        end
        {ext_clock_sel, standby_mode} <= 2'h0;
        seq_running <= 2'h3;
        rnd(40);
        rc(OFF_LOWER_STATUS, exp_lower(2'h3));
        u_host.wr(OFF_LOWER_STATUS, 16'hffff);
        rc(OFF_LOWER_STATUS, exp_lower(2'h3));
        conv_enable <= 4'h7;
        cnt[3] = 2'h0;
        rnd(30);
        rc(OFF_LOWER_STATUS, exp_lower(2'h1));
        // A low clock enable must freeze the counters although completions keep arriving.
        ce <= 1'b0;
        rnd(8);
        ce <= 1'b1;
        rc(OFF_LOWER_STATUS, exp_lower(2'h1));
        standby_mode <= 1'b1;
        foreach (cnt[i]) cnt[i] = 2'h0;
        rnd(10);
        rc(OFF_LOWER_STATUS, exp_lower(2'h1));
        standby_mode <= 1'b0;
        supply_fault_raw <= 16'h8021;
        repeat (5) @(posedge clk);
        supply_fault_raw <= 16'h0001;
        repeat (4) @(posedge clk);
        rc(OFF_SUPPLY_FAULT, 16'h7fde);
        u_host.wr(OFF_SUPPLY_FAULT, 16'h0021);
        rc(OFF_SUPPLY_FAULT, 16'h7ffe);
        supply_fault_raw <= 16'h0000;
        repeat (4) @(posedge clk);
        u_host.wr(OFF_SUPPLY_FAULT, 16'hffff);
        rc(OFF_SUPPLY_FAULT, 16'hffff);
        supply_fault_raw <= 16'h0100;
        seq_running <= 2'h0;
        repeat (5) @(posedge clk);
        supply_fault_raw <= 16'h0000;
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        rc(OFF_SUPPLY_FAULT, 16'hffff);
        rc(OFF_LOWER_STATUS, 16'h0000);
        close_out;
    end
endmodule
